// [verilog/bdds_defs.vh]
`ifndef BDDS_DEFS_VH
`define BDDS_DEFS_VH

// APB register byte offsets
`define BDDS_OFF_CTRL       12'h000
`define BDDS_OFF_HOLD       12'h004
`define BDDS_OFF_CH0_CFG    12'h008
`define BDDS_OFF_CH1_CFG    12'h00c
`define BDDS_OFF_LOAD_DATA  12'h010
`define BDDS_OFF_LOAD_CMD   12'h014
`define BDDS_OFF_STATUS     12'h018

// Control register fields
`define BDDS_CTRL_PROF_BIT  0
`define BDDS_CTRL_DYN_BIT   1
`define BDDS_CTRL_RUN_BIT   2

// Profile selector values
`define BDDS_PROF_MOVING    1'b0
`define BDDS_PROF_BIRTH     1'b1

// Channel config fields: bins in [6:0], cycled paths in [10:8]
`define BDDS_CFG_BINS_LSB   0
`define BDDS_CFG_PATHS_LSB  8

// Load command fields: group 1..8 in [3:0], channel in bit 4
`define BDDS_CMD_CH_BIT     4

// Sizes
`define BDDS_NUM_CH         2
`define BDDS_NUM_PATHS      6
`define BDDS_NUM_BINS       64
`define BDDS_GROUP_SIZE     8
`define BDDS_NUM_GROUPS     8

// Reset values and hold limit
`define BDDS_RST_HOLD_MS    16'h0001
`define BDDS_RST_BINS       7'h0b
`define BDDS_RST_PATHS      3'h2
`define BDDS_MAX_HOLD_MS    16'hea60
`define BDDS_DFLT_BIN_STEP  10000
`define BDDS_DFLT_BINS_USED 11

// Delay quantisation: inputs in 0.1 ns, step of 15 ns
`define BDDS_STEP_TENTHS    150
`define BDDS_STEP_HALF      75

// Timing: one millisecond tick at 50 MHz
`define BDDS_CLK_HZ         50000000
`define BDDS_TICK_MS        1
`define BDDS_TICK_CYCLES    ((`BDDS_CLK_HZ / 1000) * `BDDS_TICK_MS)

`endif

// [verilog/bdds_scheduler.v]
// What this block does
// - Birth-death scheduling runs only when the profile selector holds birth-death.
// - All path delays stay unchanged for the hold duration between transitions.
// - Destinations drawn only from bins one to active bin count.
// - Each transition relocates exactly one path; others keep their delay.
// - Moved path is chosen round-robin from path one to cycled path count.
// - Bin table is loaded by eight group loads, index one to eight.
// - Each load carries exactly eight values; other counts flag a syntax error.
// - Bin count, path count and bin table are held separately per channel.
// - Defaults: profile moving-propagation, hold duration one millisecond.
// - Defaults: eleven bins spaced one microsecond from zero, two cycled paths.
// - Power up reloads the default bin table, user contents are lost.
// - Arming places path n in bin n for active paths one to six.
// - First transition moves path one to a uniformly chosen unoccupied bin.
// - Run while armed starts transitions, the first one hold duration later, endless until static mode or the moving profile is selected.
// - Leaving dynamic mode restores every path to its prior static delay.
// - Only path delays are altered during the test.
// - Never two paths in one bin; new bin uniform among unoccupied.
// - Hold duration programmable one millisecond to sixty seconds, 1 ms steps.
// - Bin delays rounded to the nearest fifteen nanosecond step.
//
// Design decisions made here: the register offsets and the APB register port.
`include "bdds_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module bdds_scheduler #(
  parameter integer TICK_CYCLES = `BDDS_TICK_CYCLES
) (
  // Clock and reset
  input  wire         i_clk,
  input  wire         i_arst_n,
  // APB slave
  input  wire         i_psel,
  input  wire         i_penable,
  input  wire         i_pwrite,
  input  wire [11:0]  i_paddr,
  input  wire [31:0]  i_pwdata,
  output wire [31:0]  o_prdata,
  output wire         o_pready,
  output wire         o_pslverr,
  // Static delays per path, 15 ns steps, path 0 in the low bits
  input  wire [107:0] i_ch0_static_delay,
  input  wire [107:0] i_ch1_static_delay,
  // Applied delays per path, 15 ns steps
  output wire [107:0] o_ch0_delay,
  output wire [107:0] o_ch1_delay,
  // Mode status
  output wire         o_dyn_mode,
  output wire         o_running
);

  localparam integer NP  = `BDDS_NUM_PATHS;
  localparam integer NB  = `BDDS_NUM_BINS;
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_PICK = 2'h1;
  localparam [1:0] ST_NEXT = 2'h2;

  // Rounded step count of a delay given in 0.1 ns
  function [17:0] round_step;
    input [23:0] tenths;
    reg   [24:0] sum;
    reg   [24:0] quo;
    begin
      sum        = {1'b0, tenths} + 25'd`BDDS_STEP_HALF;
      quo        = sum / 25'd`BDDS_STEP_TENTHS;
      round_step = quo[17:0]; // Largest input gives 111848 steps, which fits in 17 bits
    end
  endfunction

  // Default table entry k, one microsecond per bin
  function [17:0] dflt_entry;
    input integer k;
    integer tenths;
    begin
      tenths = k * `BDDS_DFLT_BIN_STEP;
      if (k < `BDDS_DFLT_BINS_USED) begin
        dflt_entry = round_step(tenths[23:0]);
      end else begin
        dflt_entry = 18'h00000;
      end
    end
  endfunction

  // Starting bin of path slot k: path n sits in bin n
  function [5:0] home_bin;
    input integer k;
    integer idx;
    begin
      idx      = k % NP;
      home_bin = idx[5:0];
    end
  endfunction

  // Register state
  reg         prof_reg;
  reg         dyn_reg;
  reg         running_reg;
  reg         load_err_reg;
  reg  [15:0] hold_reg;
  reg  [6:0]  bins_reg    [0:1];
  reg  [2:0]  paths_reg   [0:1];
  reg  [17:0] table_reg   [0:2*NB-1];
  reg  [17:0] stage_reg   [0:7];
  reg  [3:0]  stage_cnt_reg;
  reg  [5:0]  bptr_reg    [0:2*NP-1];
  reg  [2:0]  next_path_reg [0:1];
  reg  [15:0] tick_cnt_reg;
  reg  [15:0] ms_cnt_reg;
  reg  [15:0] lfsr_reg;
  reg  [1:0]  state_reg;
  reg         ch_reg;

  // Bus decode
  wire        wr_en = i_psel & i_penable & i_pwrite;
  wire        mapped = (i_paddr == `BDDS_OFF_CTRL) | (i_paddr == `BDDS_OFF_HOLD) |
                       (i_paddr == `BDDS_OFF_CH0_CFG) | (i_paddr == `BDDS_OFF_CH1_CFG) |
                       (i_paddr == `BDDS_OFF_LOAD_DATA) | (i_paddr == `BDDS_OFF_LOAD_CMD) |
                       (i_paddr == `BDDS_OFF_STATUS);
  wire        wr_ok = wr_en & mapped;
  wire [3:0]  cmd_grp = i_pwdata[3:0];
  wire        cmd_ch  = i_pwdata[`BDDS_CMD_CH_BIT];
  wire        bd_active = dyn_reg & (prof_reg == `BDDS_PROF_BIRTH);

  assign o_pready   = 1'b1;
  assign o_pslverr  = i_psel & i_penable & ~mapped;
  assign o_dyn_mode = dyn_reg;
  assign o_running  = running_reg;

  // Read mux
  reg [31:0] rdata;
  always @* begin
    rdata = 32'h00000000;
    case (i_paddr)
      `BDDS_OFF_CTRL:    rdata = {29'h0, running_reg, dyn_reg, prof_reg};
      `BDDS_OFF_HOLD:    rdata = {16'h0, hold_reg};
      `BDDS_OFF_CH0_CFG: rdata = {21'h0, paths_reg[0], 1'b0, bins_reg[0]};
      `BDDS_OFF_CH1_CFG: rdata = {21'h0, paths_reg[1], 1'b0, bins_reg[1]};
      `BDDS_OFF_STATUS:  rdata = {20'h0, next_path_reg[1], 1'b0, next_path_reg[0],
                                  load_err_reg, stage_cnt_reg};
      default:           rdata = 32'h00000000;
    endcase
  end
  assign o_prdata = (i_psel & ~i_pwrite) ? rdata : 32'h00000000;

  // Millisecond tick and hold timer
  wire tick = (tick_cnt_reg == TICK_CYCLES - 1);
  wire hold_done = tick & (ms_cnt_reg >= hold_reg - 16'h0001);
  wire strobe = running_reg & hold_done;

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tick_cnt_reg <= 16'h0000;
      ms_cnt_reg   <= 16'h0000;
    end else if (!running_reg) begin
      tick_cnt_reg <= 16'h0000;
      ms_cnt_reg   <= 16'h0000;
    end else begin
      tick_cnt_reg <= tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
      if (hold_done) begin
        ms_cnt_reg <= 16'h0000;
      end else if (tick) begin
        ms_cnt_reg <= ms_cnt_reg + 16'h0001;
      end
    end
  end

  // Random source, advanced every cycle
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lfsr_reg <= 16'hace1;
    end else begin
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    end
  end

  // Candidate bin and occupancy check for the channel in work
  // Random word scaled into the active bins, so every draw is in range and
  // the pick latency stays short and nearly fixed against the hold timer
  wire [22:0] scaled = lfsr_reg * bins_reg[ch_reg];
  wire [5:0]  cand   = scaled[21:16];
  wire [2:0] mv_pth = next_path_reg[ch_reg];
  reg        occupied;
  integer    j;
  always @* begin
    occupied = 1'b0;
    for (j = 0; j < NP; j = j + 1) begin
      if ((j < paths_reg[ch_reg]) && (bptr_reg[ch_reg * NP + j] == cand)) begin
        occupied = 1'b1;
      end
    end
  end
  wire in_range = ({1'b0, cand} < bins_reg[ch_reg]);
  wire has_free = (bins_reg[ch_reg] > {4'h0, paths_reg[ch_reg]});

  // Configuration, loading and scheduler
  integer i;
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prof_reg      <= `BDDS_PROF_MOVING;
      hold_reg      <= `BDDS_RST_HOLD_MS;
      dyn_reg       <= 1'b0;
      running_reg   <= 1'b0;
      load_err_reg  <= 1'b0;
      stage_cnt_reg <= 4'h0;
      state_reg     <= ST_IDLE;
      ch_reg        <= 1'b0;
      for (i = 0; i < 2; i = i + 1) begin
        bins_reg[i]      <= `BDDS_RST_BINS;
        paths_reg[i]     <= `BDDS_RST_PATHS;
        next_path_reg[i] <= 3'h0;
      end
      for (i = 0; i < 2 * NB; i = i + 1) begin
        table_reg[i] <= dflt_entry(i % NB);
      end
      for (i = 0; i < 8; i = i + 1) begin
        stage_reg[i] <= 18'h00000;
      end
      for (i = 0; i < 2 * NP; i = i + 1) begin
        bptr_reg[i] <= 6'h00;
      end
    end else begin
      // Software writes
      if (wr_ok) begin
        case (i_paddr)
          `BDDS_OFF_CTRL: begin
            prof_reg <= i_pwdata[`BDDS_CTRL_PROF_BIT];
            dyn_reg  <= i_pwdata[`BDDS_CTRL_DYN_BIT];
            if (!i_pwdata[`BDDS_CTRL_DYN_BIT]) begin
              running_reg <= 1'b0;
              state_reg   <= ST_IDLE;
            end else if (!dyn_reg) begin
              // Arming: path n into bin n
              for (i = 0; i < 2 * NP; i = i + 1) begin
                bptr_reg[i] <= home_bin(i);
              end
              next_path_reg[0] <= 3'h0;
              next_path_reg[1] <= 3'h0;
            end else if (i_pwdata[`BDDS_CTRL_PROF_BIT] != `BDDS_PROF_BIRTH) begin
              // Moving profile selected while armed: no birth-death transitions
              running_reg <= 1'b0;
            end else if (i_pwdata[`BDDS_CTRL_RUN_BIT]) begin
              running_reg <= 1'b1;
            end
          end
          `BDDS_OFF_HOLD: begin
            if (i_pwdata[15:0] == 16'h0000) begin
              hold_reg <= `BDDS_RST_HOLD_MS;
            end else if (i_pwdata[15:0] > `BDDS_MAX_HOLD_MS) begin
              hold_reg <= `BDDS_MAX_HOLD_MS;
            end else begin
              hold_reg <= i_pwdata[15:0];
            end
          end
          `BDDS_OFF_CH0_CFG, `BDDS_OFF_CH1_CFG: begin
            if (i_pwdata[6:0] != 7'h00 && i_pwdata[6:0] <= NB) begin
              bins_reg[i_paddr[2]] <= i_pwdata[6:0];
            end
            if (i_pwdata[10:8] != 3'h0 && i_pwdata[10:8] <= NP) begin
              paths_reg[i_paddr[2]] <= i_pwdata[10:8];
            end
          end
          `BDDS_OFF_LOAD_DATA: begin
            if (stage_cnt_reg < 4'h8) begin
              stage_reg[stage_cnt_reg[2:0]] <= round_step(i_pwdata[23:0]);
            end
            if (stage_cnt_reg != 4'hf) begin
              stage_cnt_reg <= stage_cnt_reg + 4'h1;
            end
          end
          `BDDS_OFF_LOAD_CMD: begin
            stage_cnt_reg <= 4'h0;
            if (stage_cnt_reg != 4'h8 || cmd_grp == 4'h0 || cmd_grp > 4'h8) begin
              load_err_reg <= 1'b1;
            end else begin
              load_err_reg <= 1'b0;
              for (i = 0; i < 8; i = i + 1) begin
                table_reg[cmd_ch * NB + (cmd_grp - 1) * 8 + i] <= stage_reg[i];
              end
            end
          end
          default: begin
          end
        endcase
      end
      // Transition engine, one path per channel per strobe
      case (state_reg)
        ST_IDLE: begin
          if (strobe) begin
            ch_reg    <= 1'b0;
            state_reg <= ST_PICK;
          end
        end
        ST_PICK: begin
          if (!has_free) begin
            state_reg <= ST_NEXT;
          end else if (in_range && !occupied) begin
            bptr_reg[ch_reg * NP + mv_pth] <= cand;
            state_reg <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          if (mv_pth + 3'h1 >= paths_reg[ch_reg]) begin
            next_path_reg[ch_reg] <= 3'h0;
          end else begin
            next_path_reg[ch_reg] <= mv_pth + 3'h1;
          end
          if (ch_reg) begin
            state_reg <= ST_IDLE;
          end else begin
            ch_reg    <= 1'b1;
            state_reg <= ST_PICK;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Applied delay per path, only delays are touched
  genvar g;
  generate
    for (g = 0; g < 2 * NP; g = g + 1) begin : g_path
      wire [17:0] st_dly = (g < NP) ? i_ch0_static_delay[(g % NP) * 18 +: 18]
                                    : i_ch1_static_delay[(g % NP) * 18 +: 18];
      wire        in_test = bd_active && ((g % NP) < paths_reg[g / NP]);
      // One register per path, each driven by its own process only
      reg  [17:0] dly_reg;
      always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          dly_reg <= 18'h00000;
        end else if (in_test) begin
          dly_reg <= table_reg[(g / NP) * NB + bptr_reg[g]];
        end else begin
          dly_reg <= st_dly;
        end
      end
      if (g < NP) begin : g_c0
        assign o_ch0_delay[(g % NP) * 18 +: 18] = dly_reg;
      end else begin : g_c1
        assign o_ch1_delay[(g % NP) * 18 +: 18] = dly_reg;
      end
    end
  endgenerate

endmodule // bdds_scheduler
`default_nettype wire

// [verification/bdds_checker.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bdds_defs.vh"
module bdds_checker #(
  parameter integer TICK_CYCLES = 50000
) (
  // Clock and reset
  input wire logic         i_clk,
  input wire logic         i_arst_n,
  // APB
  input wire logic         i_psel,
  input wire logic         i_penable,
  input wire logic         i_pwrite,
  input wire logic [11:0]  i_paddr,
  input wire logic [31:0]  i_pwdata,
  input wire logic [31:0]  o_prdata,
  // Delays and mode
  input wire logic [107:0] i_ch0_static_delay,
  input wire logic [107:0] o_ch0_delay,
  input wire logic         o_dyn_mode,
  input wire logic         o_running
);
  logic [107:0] prev_reg;
  logic [31:0]  gap_reg;
  logic [2:0]   nd;
  // Last delays and cycles since they last changed
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prev_reg <= 108'h0;
      gap_reg  <= 32'h0;
    end else begin
      prev_reg <= o_ch0_delay;
      gap_reg  <= (o_ch0_delay != prev_reg) ? 32'h0 : gap_reg + 32'h1;
    end
  end
  // Paths whose delay moved this cycle
  always @* begin
    nd = 3'h0;
    for (int j = 0; j < 6; j++) nd = nd + 3'(o_ch0_delay[j*18+:18] != prev_reg[j*18+:18]);
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // Control write taken, and a move while running
  sequence s_ctrl_wr; i_psel && i_penable && i_pwrite && i_paddr == `BDDS_OFF_CTRL; endsequence
  sequence s_move; o_running && o_ch0_delay != prev_reg; endsequence
  property p_static; !o_dyn_mode |=> o_ch0_delay == $past(i_ch0_static_delay); endproperty
  property p_run_dyn; o_running |-> o_dyn_mode; endproperty
  property p_one; o_running && $stable(i_ch0_static_delay) |-> nd <= 3'h1; endproperty
  property p_hold; s_move |-> gap_reg >= TICK_CYCLES; endproperty
  property p_free; o_dyn_mode |-> o_ch0_delay[17:0] != o_ch0_delay[35:18]; endproperty
  property p_go; s_ctrl_wr ##0 (i_pwdata[2:0] == 3'h7 && o_dyn_mode) |=> o_running; endproperty
  property p_arm; s_ctrl_wr ##0 (i_pwdata[1] && !o_dyn_mode) |=> o_dyn_mode && !o_running;
  endproperty
  property p_stop; s_ctrl_wr ##0 !i_pwdata[1] |=> !o_dyn_mode && !o_running
    ##1 o_ch0_delay == $past(i_ch0_static_delay); endproperty
  property p_hold_rng; i_psel && !i_pwrite && i_paddr == `BDDS_OFF_HOLD
    |-> o_prdata >= 32'h1 && o_prdata <= 32'hea60; endproperty
  a_static: assert property (p_static) else $error("static delay not applied");
  a_run_dyn: assert property (p_run_dyn) else $error("running outside dynamic mode");
  a_one: assert property (p_one) else $error("more than one path moved");
  a_hold: assert property (p_hold) else $error("move before hold expired");
  a_free: assert property (p_free) else $error("two paths share a bin");
  a_go: assert property (p_go) else $error("run did not start");
  a_arm: assert property (p_arm) else $error("arm not taken");
  a_stop: assert property (p_stop) else $error("static restore failed");
  a_hold_rng: assert property (p_hold_rng) else $error("hold out of range");
endmodule // bdds_checker
bind bdds_scheduler bdds_checker #(.TICK_CYCLES(TICK_CYCLES)) u_bdds_checker (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .i_ch0_static_delay(i_ch0_static_delay), .o_ch0_delay(o_ch0_delay),
  .o_dyn_mode(o_dyn_mode), .o_running(o_running));
`default_nettype wire

// [verification/bdds_host.sv]
`timescale 1ns/1ps
`default_nettype none
module bdds_host (
  // Clock
  input  wire logic        i_clk,
  // APB master
  output var  logic        o_psel,
  output var  logic        o_penable,
  output var  logic        o_pwrite,
  output var  logic [11:0] o_paddr,
  output var  logic [31:0] o_pwdata,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr
);
  // Bus idle at time zero
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 12'h0;
    o_pwdata = 32'h0;
  end
  // One transfer: setup, access held until ready, then release
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_pready !== 1'b1 && n < 64);
    q = i_prdata;
    e = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    if (i_pready !== 1'b1) tb.stall("apb_ready");
  endtask
endmodule // bdds_host
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bdds_defs.vh"
module tb;
  localparam int TK = 50;
  logic         i_clk = 1'b0;
  logic         i_arst_n = 1'b0;
  logic         psel, penable, pwrite, pready, pslverr, dyn, run, e;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, q, kv;
  logic [107:0] st0, st1, d0, d1, pv;
  int           fails = 0;
  int           checks_done = 0;
  int           t, m;
  // 50 MHz clock
  always #10 i_clk = ~i_clk;
  bdds_scheduler #(.TICK_CYCLES(TK)) u_bdds_scheduler (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_ch0_static_delay(st0),
    .i_ch1_static_delay(st1), .o_ch0_delay(d0), .o_ch1_delay(d1), .o_dyn_mode(dyn),
    .o_running(run));
  bdds_host u_bdds_host (
    .i_clk(i_clk), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
    .o_pwdata(pwdata), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr));
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_bdds_host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
    u_bdds_host.xfer(1'b0, a, 32'h0, q, e);
    chk(nm, q, x);
  endtask
  function automatic logic [31:0] fld(input logic [107:0] v, input int i);
    return {14'h0, v[i*18+:18]};
  endfunction
  // Every path of both channels back on its static delay
  task automatic static_all();
    for (int j = 0; j < 6; j++) begin
      chk("ch0_delay", fld(d0, j), fld(st0, j));
      chk("ch1_delay", fld(d1, j), fld(st1, j));
    end
  endtask
  // Push c values for group g, then the load command
  task automatic load(input int g, input int c);
    for (int j = 0; j < c; j++) wr(`BDDS_OFF_LOAD_DATA, 32'(1500 * (8 * g - 7 + j) + 74));
    wr(`BDDS_OFF_LOAD_CMD, 32'(g));
  endtask
  task automatic stall(input string s);
    fails++;
    $display("ERROR %s expected response seen none", s);
    wrap_up();
  endtask
  task automatic wrap_up();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence; paths get distinct static delays before any arm
  initial begin
    for (int j = 0; j < 6; j++) begin
      st0[j*18+:18] = 18'h01000 + 18'(j);
      st1[j*18+:18] = 18'h02000 + 18'(j);
    end
    repeat (8) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rd(`BDDS_OFF_CTRL, 32'h0, "ctrl");
    rd(`BDDS_OFF_HOLD, 32'h1, "hold");
    rd(`BDDS_OFF_CH0_CFG, 32'h20b, "ch0_cfg");
    rd(`BDDS_OFF_CH1_CFG, 32'h20b, "ch1_cfg");
    static_all();
    $display("test defaults done");
    wr(`BDDS_OFF_CTRL, 32'h3);
    repeat (3) @(posedge i_clk);
    chk("arm_p1", fld(d0, 0), 32'h0);
    chk("arm_p2", fld(d0, 1), 32'h43);
    chk("arm_p3", fld(d0, 2), fld(st0, 2));
    chk("arm_c1", fld(d1, 1), 32'h43);
    wr(`BDDS_OFF_CTRL, 32'h0);
    repeat (3) @(posedge i_clk);
    static_all();
    $display("test default_table done");
    load(8, 7);
    rd(`BDDS_OFF_STATUS, 32'h10, "short_load");
    load(8, 9);
    rd(`BDDS_OFF_STATUS, 32'h10, "long_load");
    for (int g = 1; g <= 8; g++) load(g, 8);
    rd(`BDDS_OFF_STATUS, 32'h0, "good_load");
    wr(`BDDS_OFF_HOLD, 32'h0);
    rd(`BDDS_OFF_HOLD, 32'h1, "hold_min");
    wr(`BDDS_OFF_HOLD, 32'h0000fde8);
    rd(`BDDS_OFF_HOLD, 32'hea60, "hold_max");
    wr(`BDDS_OFF_HOLD, 32'h2);
    wr(`BDDS_OFF_CH0_CFG, 32'h305);
    rd(`BDDS_OFF_CH0_CFG, 32'h305, "ch0_cfg");
    $display("test loads done");
    wr(`BDDS_OFF_CTRL, 32'h3);
    repeat (3) @(posedge i_clk);
    for (int j = 0; j < 3; j++) chk("arm_bin", fld(d0, j), 32'(10 * j + 10));
    chk("arm_c1", fld(d1, 1), 32'h43);
    wr(`BDDS_OFF_CTRL, 32'h7);
    @(posedge i_clk);
    chk("running", {31'h0, run}, 32'h1);
    for (int n = 0; n < 7; n++) begin
      pv = d0;
      t = 0;
      while (d0 === pv && t < 400) begin
        @(posedge i_clk);
        t++;
      end
      if (t >= 400) stall("move");
      m = 9;
      for (int j = 0; j < 6; j++) if (d0[j*18+:18] !== pv[j*18+:18]) m = j;
      chk("moved_path", 32'(m), 32'(n % 3));
      kv = fld(d0, n % 3);
      chk("bin_range", 32'(kv % 10 == 0 && kv >= 10 && kv <= 50), 32'h1);
      chk("bin_free", 32'(kv != fld(d0, (n + 1) % 3) && kv != fld(d0, (n + 2) % 3)), 32'h1);
      chk("gap", 32'(t >= 85 && t <= 120), 32'h1);
      chk("path4", fld(d0, 3), fld(st0, 3));
    end
    wr(`BDDS_OFF_CTRL, 32'h0);
    repeat (3) @(posedge i_clk);
    static_all();
    $display("test run done");
    wr(`BDDS_OFF_CTRL, 32'h2);
    wr(`BDDS_OFF_CTRL, 32'h6);
    repeat (250) @(posedge i_clk);
    static_all();
    wr(`BDDS_OFF_CTRL, 32'h0);
    wr(12'h01c, 32'h7);
    chk("slverr_1c", {31'h0, e}, 32'h1);
    wr(12'h100, 32'h7);
    chk("slverr_100", {31'h0, e}, 32'h1);
    rd(`BDDS_OFF_CTRL, 32'h0, "ctrl_kept");
    $display("test moving_and_unmapped done");
    wrap_up();
  end
endmodule // tb
`default_nettype wire
